// >>> hdl/otfr_fault_response.v
// over-temperature fault response: threshold compare, action, retries and latch-off
//
// Functional notes
// - action 00: over-temperature is ignored, output keeps running.
// - action 01: keep running for the delay, then retry handling if still hot.
// - action 10: disable output at once, then follow the retry setting.
// - action 11: stay off until a clear, reset or off-then-on command.
// - retry 000: no restart; output stays off until the fault is cleared.
// - retry 001..110: one to six restarts, then off until cleared.
// - restart attempts start one programmed delay apart.
// - retry 111: retry forever until commanded off, reset or other fault.
// - delay field code n selects two to the n time units.
// - length of one time unit comes from a separate input.
// - fault when measured temperature reaches the 16-bit linear threshold.
`include "otfr_regs.vh"

module otfr_fault_response (
  input  wire        clk,
  input  wire        rst,
  input  wire        cmd_valid,
  input  wire        cmd_write,
  input  wire [7:0]  cmd_code,
  input  wire [15:0] cmd_wdata,
  input  wire        clear_faults,
  input  wire        fault_bit_clr,
  input  wire        ctrl_pin,
  input  wire        operation_on,
  input  wire        other_fault_shdn,
  input  wire        temp_valid,
  input  wire [15:0] temp_meas,
  input  wire [15:0] delay_unit_cycles,
  output reg  [15:0] rd_data_q,
  output reg         rd_valid_q,
  output reg         cmd_err_q,
  output reg         out_en_q,
  output reg         fault_flag_q,
  output reg  [2:0]  resp_state_q,
  output reg  [2:0]  retry_left_q
);

  localparam [2:0] S_OFF   = 3'h0;
  localparam [2:0] S_RUN   = 3'h1;
  localparam [2:0] S_DELAY = 3'h2;
  localparam [2:0] S_WAIT  = 3'h3;
  localparam [2:0] S_LATCH = 3'h4;

  reg  [7:0]  resp_q;
  reg  [15:0] limit_q;
  reg         ctrl_meta_q;
  reg         ctrl_sync_q;
  reg         ot_q;
  reg  [2:0]  snap_rty_q;
  reg  [2:0]  snap_dly_q;
  reg  [2:0]  state_d;
  reg  [2:0]  retry_left_d;
  reg  [2:0]  snap_rty_d;
  reg  [2:0]  snap_dly_d;
  reg         trip_set;
  reg         tmr_start;
  reg         tmr_stop;
  reg  [2:0]  tmr_code;
  wire        tmr_done;
  wire        tmr_busy;
  wire        cmd_on;
  wire        clr_any;
  wire        fault_flag_d;
  wire [1:0]  cfg_act;
  wire [2:0]  cfg_rty;
  wire [2:0]  cfg_dly;

  // linear value as signed fixed point with sixteen fraction bits
  function signed [47:0] lin_to_fix;
    input [15:0] v;
    reg   [4:0]  sh;
    reg   signed [47:0] man;
    begin
      sh  = v[`OTFR_LIN_EXP_HI:`OTFR_LIN_EXP_LO] ^ `OTFR_LIN_EXP_OFS;
      man = {{37{v[`OTFR_LIN_MAN_HI]}}, v[`OTFR_LIN_MAN_HI:0]};
      lin_to_fix = man <<< sh;
    end
  endfunction

  // field views of the live response register
  assign cfg_act = resp_q[`OTFR_ACT_HI:`OTFR_ACT_LO];
  assign cfg_rty = resp_q[`OTFR_RTY_HI:`OTFR_RTY_LO];
  assign cfg_dly = resp_q[`OTFR_DLY_HI:`OTFR_DLY_LO];

  // output is wanted only while both the pin and the operation command say on
  assign cmd_on  = ctrl_sync_q & operation_on;
  assign clr_any = clear_faults | fault_bit_clr;

  // remote-control pin passes two flip-flops before use
  always @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_meta_q <= 1'b0;
      ctrl_sync_q <= 1'b0;
    end
    else
    begin
      ctrl_meta_q <= ctrl_pin;
      ctrl_sync_q <= ctrl_meta_q;
    end
  end

  // host register port: byte response register and word threshold register
  always @(posedge clk)
  begin
    if (rst)
    begin
      resp_q     <= `OTFR_RESP_RST;
      limit_q    <= `OTFR_LIMIT_RST;
      rd_data_q  <= 16'h0000;
      rd_valid_q <= 1'b0;
      cmd_err_q  <= 1'b0;
    end
    else
    begin
      rd_valid_q <= 1'b0;
      cmd_err_q  <= 1'b0;
      if (cmd_valid)
      begin
        if (cmd_code == `OTFR_CODE_RESP)
        begin
          if (cmd_write)
          begin
            resp_q <= cmd_wdata[7:0];
          end
          else
          begin
            rd_data_q  <= {`OTFR_RD_PAD, resp_q};
            rd_valid_q <= 1'b1;
          end
        end
        else if (cmd_code == `OTFR_CODE_LIMIT)
        begin
          if (cmd_write)
          begin
            limit_q <= cmd_wdata;
          end
          else
          begin
            rd_data_q  <= limit_q;
            rd_valid_q <= 1'b1;
          end
        end
        else
        begin
          cmd_err_q <= 1'b1; // unsupported code, nothing changes
        end
      end
    end
  end

  // over-temperature level, refreshed on each new measurement
  always @(posedge clk)
  begin
    if (rst)
    begin
      ot_q <= 1'b0;
    end
    else if (temp_valid)
    begin
      ot_q <= (lin_to_fix(temp_meas) >= lin_to_fix(limit_q));
    end
  end

  // response state machine
  always @*
  begin
    state_d      = resp_state_q;
    retry_left_d = retry_left_q;
    snap_rty_d   = snap_rty_q;
    snap_dly_d   = snap_dly_q;
    trip_set     = 1'b0;
    tmr_start    = 1'b0;
    tmr_code     = snap_dly_q;
    if (!cmd_on)
    begin
      state_d = S_OFF;
    end
    else
    begin
      case (resp_state_q)
        S_OFF:
        begin
          state_d = S_RUN;
        end
        S_RUN:
        begin
          if (ot_q && (cfg_act != `OTFR_ACT_IGNORE))
          begin
            trip_set   = 1'b1;
            snap_rty_d = cfg_rty;
            snap_dly_d = cfg_dly;
            tmr_code   = cfg_dly;
            if (cfg_act == `OTFR_ACT_DELAY)
            begin
              tmr_start = 1'b1;
              state_d   = S_DELAY;
            end
            else if (cfg_act == `OTFR_ACT_RETRY)
            begin
              if (cfg_rty == `OTFR_RTY_NONE)
              begin
                state_d = S_LATCH;
              end
              else
              begin
                retry_left_d = cfg_rty;
                tmr_start    = 1'b1;
                state_d      = S_WAIT;
              end
            end
            else
            begin
              state_d = S_LATCH;
            end
          end
        end
        S_DELAY:
        begin
          if (tmr_done)
          begin
            if (!ot_q)
            begin
              state_d = S_RUN;
            end
            else if (snap_rty_q == `OTFR_RTY_NONE)
            begin
              state_d = S_LATCH;
            end
            else
            begin
              retry_left_d = snap_rty_q;
              tmr_start    = 1'b1;
              state_d      = S_WAIT;
            end
          end
        end
        S_WAIT:
        begin
          if (other_fault_shdn)
          begin
            state_d = S_LATCH;
          end
          else if (tmr_done)
          begin
            if (!ot_q)
            begin
              state_d = S_RUN; // restart attempt succeeded
            end
            else if (snap_rty_q == `OTFR_RTY_CONT)
            begin
              tmr_start = 1'b1;
            end
            else if (retry_left_q == `OTFR_RTY_ONE)
            begin
              state_d = S_LATCH;
            end
            else
            begin
              retry_left_d = retry_left_q - `OTFR_RTY_ONE;
              tmr_start    = 1'b1;
            end
          end
        end
        S_LATCH:
        begin
          if (clr_any)
          begin
            state_d = S_RUN;
          end
        end
        default:
        begin
          state_d = S_OFF;
        end
      endcase
    end
    tmr_stop = tmr_busy & ~tmr_start & (state_d != S_DELAY) & (state_d != S_WAIT);
  end

  // status bit: a trip in the same cycle as a clear keeps the bit set
  assign fault_flag_d = trip_set | (fault_flag_q & ~clr_any);

  // state, snapshot and output registers
  always @(posedge clk)
  begin
    if (rst)
    begin
      resp_state_q <= S_OFF;
      retry_left_q <= 3'h0;
      snap_rty_q   <= 3'h0;
      snap_dly_q   <= 3'h0;
      out_en_q     <= 1'b0;
      fault_flag_q <= 1'b0;
    end
    else
    begin
      resp_state_q <= state_d;
      retry_left_q <= retry_left_d;
      snap_rty_q   <= snap_rty_d;
      snap_dly_q   <= snap_dly_d;
      out_en_q     <= (state_d == S_RUN) || (state_d == S_DELAY);
      fault_flag_q <= fault_flag_d;
    end
  end

  // shared timer for the operate delay and the restart spacing
  otfr_delay_timer u_timer (
    .clk         (clk),
    .rst         (rst),
    .start       (tmr_start),
    .stop        (tmr_stop),
    .mult_code   (tmr_code),
    .unit_cycles (delay_unit_cycles),
    .done_q      (tmr_done),
    .busy_q      (tmr_busy)
  );

endmodule

// >>> common/otfr_regs.vh
// constants for the over-temperature fault response block
`ifndef OTFR_REGS_VH
`define OTFR_REGS_VH

// command codes on the host register port
`define OTFR_CODE_RESP    8'h50
`define OTFR_CODE_LIMIT   8'h4f

// response register field positions
`define OTFR_ACT_HI       7
`define OTFR_ACT_LO       6
`define OTFR_RTY_HI       5
`define OTFR_RTY_LO       3
`define OTFR_DLY_HI       2
`define OTFR_DLY_LO       0

// action field encodings
`define OTFR_ACT_IGNORE   2'h0
`define OTFR_ACT_DELAY    2'h1
`define OTFR_ACT_RETRY    2'h2
`define OTFR_ACT_LATCH    2'h3

// retry field encodings
`define OTFR_RTY_NONE     3'h0
`define OTFR_RTY_ONE      3'h1
`define OTFR_RTY_CONT     3'h7

// reset values
`define OTFR_RESP_RST     8'h80
`define OTFR_LIMIT_RST    16'h007d

// linear format: exponent bits, mantissa bits, offset that makes the shift positive
`define OTFR_LIN_EXP_HI   15
`define OTFR_LIN_EXP_LO   11
`define OTFR_LIN_MAN_HI   10
`define OTFR_LIN_EXP_OFS  5'h10

// delay multiplier base and upper-byte fill on reads
`define OTFR_MULT_BASE    8'h01
`define OTFR_RD_PAD       8'h00

`endif

// >>> hdl/otfr_delay_timer.v
// power-of-two delay timer counted in time units of programmable length
`include "otfr_regs.vh"

module otfr_delay_timer (
  input  wire        clk,
  input  wire        rst,
  input  wire        start,
  input  wire        stop,
  input  wire [2:0]  mult_code,
  input  wire [15:0] unit_cycles,
  output reg         done_q,
  output reg         busy_q
);

  reg  [15:0] tick_cnt_q;
  reg  [7:0]  unit_cnt_q;
  reg  [7:0]  target_q;
  wire [15:0] unit_last;
  wire        unit_end;

  // a unit length of zero is treated as one cycle
  assign unit_last = (unit_cycles == 16'h0000) ? 16'h0000 : unit_cycles - 16'h0001;
  assign unit_end  = (tick_cnt_q >= unit_last);

  // count ticks inside a unit, then units up to the decoded multiplier
  always @(posedge clk)
  begin
    if (rst)
    begin
      tick_cnt_q <= 16'h0000;
      unit_cnt_q <= 8'h00;
      target_q   <= 8'h00;
      done_q     <= 1'b0;
      busy_q     <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start)
      begin
        tick_cnt_q <= 16'h0000;
        unit_cnt_q <= 8'h00;
        target_q   <= `OTFR_MULT_BASE << mult_code;
        busy_q     <= 1'b1;
      end
      else if (stop)
      begin
        busy_q <= 1'b0;
      end
      else if (busy_q)
      begin
        if (unit_end)
        begin
          tick_cnt_q <= 16'h0000;
          if (unit_cnt_q + 8'h01 == target_q)
          begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
          else
          begin
            unit_cnt_q <= unit_cnt_q + 8'h01;
          end
        end
        else
        begin
          tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
      end
    end
  end

endmodule

// >>> bench/otfr_host.sv
// host model that issues register commands to the fault response block
module otfr_host (
  input  wire logic        clk,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // one command cycle; idle lines are scrambled so stale values never match
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = d;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_code = ~c;
    cmd_wdata = ~d;
  endtask

  // idle at time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
endmodule

// >>> bench/otfr_monitor.sv
// port assertions for the fault response block
module otfr_mon (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic        other_fault_shdn,
  input wire logic [15:0] rd_data_q,
  input wire logic        rd_valid_q,
  input wire logic        cmd_err_q,
  input wire logic        out_en_q,
  input wire logic        fault_flag_q,
  input wire logic [2:0]  resp_state_q
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [1:0] act_q;

  // copy of the action field, tracked from host writes
  always @(posedge clk)
    if (rst)
      act_q <= 2'h2;
    else if (cmd_valid && cmd_write && cmd_code == 8'h50)
      act_q <= cmd_wdata[7:6];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_rdv;
    cmd_valid && !cmd_write && cmd_code == 8'h50 |=> rd_valid_q && rd_data_q[15:8] == 8'h00;
  endproperty
  a_rdv: assert property (p_rdv) else $error("response read answer wrong");
  property p_err;
    cmd_valid && cmd_code != 8'h50 && cmd_code != 8'h4f |=> cmd_err_q && !rd_valid_q;
  endproperty
  a_err: assert property (p_err) else $error("unknown code not refused");
  property p_rst;
    disable iff (1'b0) rst |=> !out_en_q && resp_state_q == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset left output on");
  property p_woff;
    resp_state_q == 3'h3 |-> !out_en_q;
  endproperty
  a_woff: assert property (p_woff) else $error("output on while waiting");
  property p_loff;
    resp_state_q == 3'h4 |-> !out_en_q && fault_flag_q;
  endproperty
  a_loff: assert property (p_loff) else $error("latched off state wrong");
  property p_dly;
    $rose(resp_state_q == 3'h2) |-> out_en_q && $past(out_en_q);
  endproperty
  a_dly: assert property (p_dly) else $error("output dropped in delay");
  property p_ign;
    act_q == 2'h0 && resp_state_q == 3'h1 |=> resp_state_q <= 3'h1;
  endproperty
  a_ign: assert property (p_ign) else $error("ignored fault acted on");
  property p_oth;
    resp_state_q == 3'h3 && other_fault_shdn |=> resp_state_q != 3'h3;
  endproperty
  a_oth: assert property (p_oth) else $error("retrying after other fault");
  property p_trip;
    resp_state_q == 3'h1 ##1 resp_state_q == 3'h3 |-> fault_flag_q;
  endproperty
  a_trip: assert property (p_trip) else $error("trip did not set flag");

  c_latch: cover property (resp_state_q == 3'h3 ##1 resp_state_q == 3'h4);
  c_dly: cover property (resp_state_q == 3'h2);
  c_rerun: cover property (resp_state_q == 3'h3 ##1 resp_state_q == 3'h1);
endmodule

bind otfr_fault_response otfr_mon u_mon (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
  .other_fault_shdn(other_fault_shdn), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
  .cmd_err_q(cmd_err_q), .out_en_q(out_en_q), .fault_flag_q(fault_flag_q),
  .resp_state_q(resp_state_q));

// >>> bench/tb_over_temp_fault_response.sv
// self-checking bench for the over-temperature fault response block
module tb_over_temp_fault_response;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, cmd_valid, cmd_write, clear_faults, fault_bit_clr, ctrl_pin;
  logic        operation_on, other_fault_shdn, temp_valid, rd_valid_q, cmd_err_q;
  logic        out_en_q, fault_flag_q;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, temp_meas, delay_unit_cycles, rd_data_q;
  logic [2:0]  resp_state_q, retry_left_q;
  int          failures, cmp_count, cyc, n, k;

  otfr_fault_response u_dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .clear_faults(clear_faults), .fault_bit_clr(fault_bit_clr), .ctrl_pin(ctrl_pin),
    .operation_on(operation_on), .other_fault_shdn(other_fault_shdn),
    .temp_valid(temp_valid), .temp_meas(temp_meas), .delay_unit_cycles(delay_unit_cycles),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .cmd_err_q(cmd_err_q),
    .out_en_q(out_en_q), .fault_flag_q(fault_flag_q), .resp_state_q(resp_state_q),
    .retry_left_q(retry_left_q));
  otfr_host u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

  // compare helpers and stimulus steps, all on falling edges
  task automatic chk(input bit ok, input string m);
    cmp_count++;
    if (!ok)
    begin
      failures++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic wait_st(input logic [2:0] s, input int lim);
    n = 0;
    while (resp_state_q !== s && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    chk(resp_state_q === s, "state not reached");
  endtask
  task automatic temp(input logic [15:0] t);
    @(negedge clk);
    temp_meas = t;
    temp_valid = 1'b1;
    @(negedge clk);
    temp_valid = 1'b0;
  endtask
  task automatic clr(input bit ind);
    @(negedge clk);
    {clear_faults, fault_bit_clr} = ind ? 2'b01 : 2'b10;
    @(negedge clk);
    {clear_faults, fault_bit_clr} = 2'b00;
  endtask
  task automatic cfg(input logic [7:0] r, input logic [15:0] u);
    u_host.xfer(1'b1, 8'h50, {8'h00, r});
    delay_unit_cycles = u;
  endtask
  task automatic rdchk(input logic [7:0] c, input logic [15:0] e);
    u_host.xfer(1'b0, c, 16'h0000);
    chk(rd_valid_q === 1'b1 && cmd_err_q === 1'b0 && rd_data_q === e, "read data");
  endtask
  task automatic recover(input bit ind);
    temp(16'h0019);
    clr(ind);
    wait_st(3'h1, 6);
    chk(out_en_q === 1'b1 && fault_flag_q === 1'b0, "no restart after clear");
  endtask

  // register reads, byte-wide write, refused code
  task automatic t_regs;
    rdchk(8'h50, 16'h0080);
    rdchk(8'h4f, 16'h007d);
    u_host.xfer(1'b1, 8'h4f, 16'h0064);
    rdchk(8'h4f, 16'h0064);
    u_host.xfer(1'b1, 8'h4f, 16'h007d);
    cfg(8'h3c, 16'h0001);
    u_host.xfer(1'b1, 8'h50, 16'hab5a);
    rdchk(8'h50, 16'h005a);
    u_host.xfer(1'b0, 8'h51, 16'h0000);
    chk(cmd_err_q === 1'b1 && rd_valid_q === 1'b0, "bad code accepted");
  endtask
  // ignore action keeps running, then latch-off and its clears
  task automatic t_latch;
    cfg(8'h00, 16'h0001);
    temp(16'h00c8);
    repeat (20) @(negedge clk);
    chk(out_en_q === 1'b1 && fault_flag_q === 1'b0, "ignored fault acted");
    temp(16'h007c);
    cfg(8'hc0, 16'h0001);
    repeat (4) @(negedge clk);
    chk(resp_state_q === 3'h1 && out_en_q === 1'b1, "tripped below limit");
    temp(16'h007d);
    wait_st(3'h4, 4);
    repeat (30) @(negedge clk);
    chk(resp_state_q === 3'h4 && out_en_q === 1'b0, "latch released");
    recover(1'b0);
    temp(16'h00c8);
    wait_st(3'h4, 4);
    recover(1'b1);
    temp(16'h00c8);
    wait_st(3'h4, 4);
    operation_on = 1'b0;
    wait_st(3'h0, 4);
    temp(16'h0019);
    operation_on = 1'b1;
    wait_st(3'h1, 4);
    temp(16'h00c8);
    wait_st(3'h4, 4);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    wait_st(3'h1, 5);
    chk(out_en_q === 1'b1 && fault_flag_q === 1'b0, "reset kept fault");
    rdchk(8'h50, 16'h0080);
    temp(16'h0019);
  endtask
  // each retry count from one to six, spaced by 4 cycles, ends latched while hot
  task automatic t_retry;
    for (k = 1; k <= 6; k++)
    begin
      cfg(8'h81 | 8'(k << 3), 16'h0002);
      temp(16'h00c8);
      wait_st(3'h3, 4);
      chk(retry_left_q === 3'(k) && out_en_q === 1'b0, "retry count not loaded");
      wait_st(3'h4, 60);
      chk(n >= 4 * k - 1 && n <= 6 * k + 2, "retry count or spacing");
      recover(1'b0);
    end
    cfg(8'h8a, 16'h0001);
    temp(16'h00c8);
    wait_st(3'h3, 4);
    temp(16'h0019);
    wait_st(3'h1, 20);
    chk(n + 2 >= 4 && n + 2 <= 7 && out_en_q === 1'b1, "restart time");
  endtask
  // delay while running for every multiplier code
  task automatic t_delay;
    for (k = 0; k < 8; k++)
    begin
      cfg(8'h40 | 8'(k), 16'h0001);
      temp(16'h00c8);
      wait_st(3'h2, 4);
      wait_st(3'h4, 300);
      chk(n >= (1 << k) && n <= (1 << k) + 3, "delay length");
      recover(1'b0);
    end
    cfg(8'h43, 16'h0001);
    temp(16'h00c8);
    wait_st(3'h2, 4);
    temp(16'h0019);
    wait_st(3'h1, 12);
    chk(out_en_q === 1'b1 && n >= 4, "no return after cool delay");
    cfg(8'h49, 16'h0001);
    temp(16'h00c8);
    wait_st(3'h3, 10);
    chk(out_en_q === 1'b0 && retry_left_q === 3'h1, "delay then retry");
    wait_st(3'h4, 10);
    recover(1'b0);
  endtask
  // continuous retry ends only on other fault or command off
  task automatic t_cont;
    cfg(8'hb8, 16'h0001);
    temp(16'h00c8);
    wait_st(3'h3, 4);
    repeat (60) @(negedge clk);
    chk(resp_state_q === 3'h3, "continuous retry stopped");
    other_fault_shdn = 1'b1;
    wait_st(3'h4, 3);
    other_fault_shdn = 1'b0;
    recover(1'b0);
    temp(16'h00c8);
    wait_st(3'h3, 4);
    ctrl_pin = 1'b0;
    wait_st(3'h0, 5);
    ctrl_pin = 1'b1;
  endtask

  // verdict and end of run
  task automatic end_sim;
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      failures++;
      end_sim;
    end
  end

  // main sequence
  initial
  begin
    {rst, clear_faults, fault_bit_clr, other_fault_shdn, temp_valid} = 5'b10000;
    {ctrl_pin, operation_on} = 2'b11;
    temp_meas = 16'h0019;
    delay_unit_cycles = 16'h0001;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    wait_st(3'h1, 5);
    t_regs;
    t_latch;
    t_retry;
    t_delay;
    t_cont;
    end_sim;
  end
endmodule
